// ==== logic/sopa_pkg.sv ====
// shared constants of the sum-of-products array, and its product-term group slice.
// assumes one clock domain; the slice is purely combinational and is used by sopa_array.

// ==========================================================
// constants
package sopa_pkg;
  localparam int          NUM_LINES   = 20;
  localparam int          NUM_DED     = 12;
  localparam int          NUM_OUT     = 8;
  localparam int          TERMS_GRP   = 8;
  localparam int          NUM_TERMS   = NUM_OUT * TERMS_GRP;
  localparam int          ROW_BITS    = 2 * NUM_LINES;
  localparam int          TERM_IDX_W  = 6;
  localparam int          OE_TERM     = 0;
  localparam logic [7:0]  REG_RST_VAL = 8'hFF;
  localparam logic [7:0]  OEN_RST_VAL = 8'hFF;
  localparam logic [11:0] DED_RST_VAL = 12'h000;
  localparam logic [39:0] VER_RST_VAL = 40'h00_0000_0000;
endpackage : sopa_pkg

// ==========================================================
// one group of product terms feeding one fixed or gate
module sopa_term_group #(
  parameter int ROW_W = 40,
  parameter int TERMS = 8
) (
  input  wire logic [ROW_W-1:0]       lines,
  input  wire logic [TERMS*ROW_W-1:0] map,
  input  wire logic                   polarity_high,
  input  wire logic                   registered,
  output logic                        sum_pin,
  output logic                        oe_term
);
  logic [TERMS-1:0] term;

  // a connected line (map bit 1) must be high; an empty term reads as one
  always_comb begin
    for (int t = 0; t < TERMS; t++) begin
      term[t] = &(lines | ~map[t*ROW_W +: ROW_W]);
    end
  end

  always_comb begin
    logic s;
    s = 1'b0;
    for (int t = 0; t < TERMS; t++) begin
      // combinatorial outputs give their first term to the enable
      if (registered || t != sopa_pkg::OE_TERM) begin
        s = s | term[t];
      end
    end
    sum_pin = polarity_high ? s : ~s;
    oe_term = term[sopa_pkg::OE_TERM];
  end
endmodule : sopa_term_group

// ==== logic/sopa_array.sv ====
// top of the sum-of-products logic array: and plane, fixed or plane, output cells.
// assumes surrounding board logic drives pins asynchronously to clk; ded_in, io_in, oe_pin_n
// and reg_clk_pin are synchronised, preload and verify inputs are not. the pattern is static parameters, set before elaboration.
// line map of the and plane: 0..11 dedicated inputs, 12..19 one feedback per output;
// each line enters true on an even row bit and complemented on the odd bit above it.
// there is no reset pin of its own: reset_n stands for power-up.
module sopa_array #(
  parameter int                                          N_OUT      = sopa_pkg::NUM_OUT,
  parameter int                                          N_DED      = sopa_pkg::NUM_DED,
  parameter int                                          GRP_TERMS  = sopa_pkg::TERMS_GRP,
  parameter logic [sopa_pkg::NUM_TERMS*sopa_pkg::ROW_BITS-1:0] AND_MAP = '0,
  parameter logic [7:0]                                  POL_HIGH   = 8'hFF,
  parameter logic [7:0]                                  REG_OUT    = 8'hFF,
  parameter logic                                        SEC_LOCK   = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [N_DED-1:0]      ded_in,
  input  wire logic                  reg_clk_pin,
  input  wire logic                  oe_pin_n,
  input  wire logic [N_OUT-1:0]      io_in,
  output logic      [N_OUT-1:0]      io_out,
  output logic      [N_OUT-1:0]      io_oe_n,
  input  wire logic                  preload_en,
  input  wire logic [N_OUT-1:0]      preload_data,
  input  wire logic                  verify_req,
  input  wire logic [sopa_pkg::TERM_IDX_W-1:0] verify_row,
  output logic      [sopa_pkg::ROW_BITS-1:0]   verify_data
);
  localparam int ROW_W = sopa_pkg::ROW_BITS;
  localparam int NLINE = sopa_pkg::NUM_LINES;

  // ==========================================================
  // state
  typedef struct packed {
    // pin synchronisers: three stages, then the agreed level
    logic [N_DED-1:0] ded_s1;
    logic [N_DED-1:0] ded_s2;
    logic [N_DED-1:0] ded_s3;
    logic [N_DED-1:0] ded_v;
    logic [N_OUT-1:0] io_s1;
    logic [N_OUT-1:0] io_s2;
    logic [N_OUT-1:0] io_s3;
    logic [N_OUT-1:0] io_v;
    // enable and register clock pins
    logic [2:0]       oe_s;
    logic             oe_v;
    logic [2:0]       ck_s;
    logic             ck_v;
    // output cells: register in pin levels, pin value, pin enable
    logic [N_OUT-1:0] reg_q;
    logic [N_OUT-1:0] out_q;
    logic [N_OUT-1:0] oen_q;
    // last captured pattern row
    logic [ROW_W-1:0] ver_q;
  } sopa_state_t;

  sopa_state_t st_q;
  sopa_state_t st_d;

  logic [ROW_W-1:0] lines;
  logic [N_OUT-1:0] sum_pin;
  logic [N_OUT-1:0] oe_term;
  logic             ck_rise;
  logic             row_ok;

  // ==========================================================
  // and plane inputs: dedicated pins, then one feedback line per output
  always_comb begin
    lines = '0;
    for (int i = 0; i < NLINE; i++) begin
      logic v;
      v = 1'b0;
      if (i < N_DED) begin
        v = st_q.ded_v[i];
      end else if (i - N_DED < N_OUT) begin
        // registered cells feed back their own state, others their pin
        v = REG_OUT[i-N_DED] ? st_q.reg_q[i-N_DED] : st_q.io_v[i-N_DED];
      end
      lines[2*i]   = v;
      lines[2*i+1] = ~v;
    end
  end

  // ==========================================================
  // product-term groups, one per output
  // every group sees all forty row lines; its map slice carries its eight rows
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_grp
      sopa_term_group #(
        .ROW_W (ROW_W),
        .TERMS (GRP_TERMS)
      ) u_grp (
        .lines         (lines),
        .map           (AND_MAP[g*GRP_TERMS*ROW_W +: GRP_TERMS*ROW_W]),
        .polarity_high (POL_HIGH[g]),
        .registered    (REG_OUT[g]),
        .sum_pin       (sum_pin[g]),
        .oe_term       (oe_term[g])
      );
    end
  endgenerate

  // ==========================================================
  // next state
  // the register clock pin is sampled, so each of its phases must span three clk periods;
  // ck_v holds the agreed level, so one rising edge never loads twice
  assign ck_rise = !st_q.ck_v && (st_q.ck_s[1] == st_q.ck_s[2]) && st_q.ck_s[2];

  // read-back address check; the lock blanks read-back only, never the array
  assign row_ok = !SEC_LOCK && (int'(verify_row) < sopa_pkg::NUM_TERMS);

  always_comb begin
    // every field holds unless a branch below moves it
    st_d = st_q;

    // ======================================================
    // three-stage synchronisers; a change counts once stages two and three agree
    // io_in matters only to combinatorial cells; registered cells feed back their own state
    st_d.ded_s1 = ded_in;
    st_d.ded_s2 = st_q.ded_s1;
    st_d.ded_s3 = st_q.ded_s2;
    st_d.io_s1  = io_in;
    st_d.io_s2  = st_q.io_s1;
    st_d.io_s3  = st_q.io_s2;
    st_d.oe_s   = {st_q.oe_s[1:0], oe_pin_n};
    st_d.ck_s   = {st_q.ck_s[1:0], reg_clk_pin};
    for (int i = 0; i < N_DED; i++) begin
      if (st_q.ded_s2[i] == st_q.ded_s3[i]) begin
        st_d.ded_v[i] = st_q.ded_s3[i];
      end
    end
    for (int i = 0; i < N_OUT; i++) begin
      if (st_q.io_s2[i] == st_q.io_s3[i]) begin
        st_d.io_v[i] = st_q.io_s3[i];
      end
    end
    if (st_q.oe_s[1] == st_q.oe_s[2]) begin
      st_d.oe_v = st_q.oe_s[2];
    end
    if (st_q.ck_s[1] == st_q.ck_s[2]) begin
      st_d.ck_v = st_q.ck_s[2];
    end

    // ======================================================
    // preload wins over the clock so a tester can park the registers
    // preload is a same-clock level: held high, it reloads on every edge
    if (preload_en) begin
      st_d.reg_q = preload_data;
    end else if (ck_rise) begin
      for (int i = 0; i < N_OUT; i++) begin
        if (REG_OUT[i]) begin
          st_d.reg_q[i] = sum_pin[i];
        end
      end
    end

    // ======================================================
    // output cells; reg_q already holds the pin level, polarity applied at load
    // combinatorial results pass one more flop, so they lag their inputs by one clk:
    // the price of driving every pin straight from a register
    for (int i = 0; i < N_OUT; i++) begin
      if (REG_OUT[i]) begin
        st_d.out_q[i] = st_q.reg_q[i];
        st_d.oen_q[i] = st_q.oe_v;
      end else begin
        st_d.out_q[i] = sum_pin[i];
        st_d.oen_q[i] = ~oe_term[i];
      end
    end

    // ======================================================
    // read-back of one term row; locked parts show nothing
    // the captured row stands until the next request
    if (verify_req) begin
      if (!row_ok) begin
        st_d.ver_q = '0;
      end else begin
        st_d.ver_q = AND_MAP[verify_row*ROW_W +: ROW_W];
      end
    end
  end

  // ==========================================================
  // registers; reset stands for power-up, the register clock is assumed idle during it
  // the oe synchroniser powers up disabled, so no registered pin drives before the enable is seen
  // reg_q powers up high at the pin whatever the polarity bit says
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q        <= '0;
      st_q.ded_v  <= sopa_pkg::DED_RST_VAL;
      st_q.oe_v   <= 1'b1;
      st_q.oe_s   <= 3'h7;
      st_q.reg_q  <= sopa_pkg::REG_RST_VAL;
      st_q.out_q  <= sopa_pkg::REG_RST_VAL;
      st_q.oen_q  <= sopa_pkg::OEN_RST_VAL;
      st_q.ver_q  <= sopa_pkg::VER_RST_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs: straight from the state flops
  assign io_out      = st_q.out_q;
  assign io_oe_n     = st_q.oen_q;
  assign verify_data = st_q.ver_q;
endmodule : sopa_array

// ==== verif/sopa_array_asserts.sv ====
// pin-level assertions of the sum-of-products array, bound into every sopa_array.
// assumes one clock domain; the board keeps the register clock low around a preload.
module sopa_array_chk #(
  parameter int         N_OUT    = 8,
  parameter logic [7:0] REG_OUT  = 8'hFF,
  parameter logic       SEC_LOCK = 1'b0
) (
  input wire logic                          clk,
  input wire logic                          reset_n,
  input wire logic                          reg_clk_pin,
  input wire logic                          oe_pin_n,
  input wire logic [N_OUT-1:0]              io_out,
  input wire logic [N_OUT-1:0]              io_oe_n,
  input wire logic                          preload_en,
  input wire logic [N_OUT-1:0]              preload_data,
  input wire logic                          verify_req,
  input wire logic [sopa_pkg::ROW_BITS-1:0] verify_data
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [N_OUT-1:0] RM = REG_OUT[N_OUT-1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ======
  // assertions
  a_reset_high: assert property ($rose(reset_n) |-> (io_out & RM) == RM)
    else $error("registered pin not high after reset");
  a_reset_float: assert property ($rose(reset_n) |-> &io_oe_n)
    else $error("pin driven right after reset");
  a_preload_load: assert property ((!reg_clk_pin)[*4] ##0 preload_en ##1 !preload_en
    |=> (io_out & RM) == ($past(preload_data, 2) & RM)) else $error("preload value not on pins");
  a_reg_hold: assert property ((!reg_clk_pin && !preload_en)[*6] |=> $stable(io_out & RM))
    else $error("registered pin moved without clock edge");
  a_oe_off: assert property (oe_pin_n[*6] |-> (io_oe_n & RM) == RM)
    else $error("registered pin driven while disabled");
  a_oe_on: assert property ((!oe_pin_n)[*6] |-> (io_oe_n & RM) == '0)
    else $error("registered pin floats while enabled");
  a_verify_lock: assert property (verify_req && SEC_LOCK |=> verify_data == '0)
    else $error("pattern visible while locked");
  a_verify_hold: assert property (!verify_req |=> $stable(verify_data))
    else $error("read-back row changed without request");
  c_preload: cover property (preload_en ##1 !preload_en);
  c_reg_clk: cover property ($rose(reg_clk_pin));
  c_verify: cover property (verify_req);
endmodule : sopa_array_chk

bind sopa_array sopa_array_chk #(.N_OUT(N_OUT), .REG_OUT(REG_OUT), .SEC_LOCK(SEC_LOCK)) u_chk (
  .clk(clk), .reset_n(reset_n), .reg_clk_pin(reg_clk_pin), .oe_pin_n(oe_pin_n), .io_out(io_out),
  .io_oe_n(io_oe_n), .preload_en(preload_en), .preload_data(preload_data), .verify_req(verify_req),
  .verify_data(verify_data));

// ==== verif/sopa_board.sv ====
// board model: makes the register clock on request and reads the pins back.
// assumes tick is driven off the falling edge of clk.
module sopa_board #(
  parameter int WAIT = 4
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       tick,
  input  wire logic [7:0] io_out,
  input  wire logic [7:0] io_oe_n,
  output logic      [7:0] io_in,
  output logic            reg_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph_q;
  int wait_q;
  // released pins read high: the board has pull-ups
  assign io_in = io_out | io_oe_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_q        <= 0;
      wait_q      <= 0;
      reg_clk_pin <= 1'b0;
    end else begin
      wait_q <= (wait_q < WAIT) ? wait_q + 1 : wait_q;
      if (ph_q != 0) begin
        ph_q <= ph_q - 1;
      end else if (tick && wait_q == WAIT) begin
        ph_q <= 8;
      end
      // four clocks high, five or more low: above the three-clock minimum
      reg_clk_pin <= (ph_q > 4);
    end
  end
endmodule : sopa_board

// ==== verif/sopa_array_bench.sv ====
// bench of the array: a table of pin cases, then hand tests.
// assumes the board model makes the register clock; clk runs at 50 MHz.
module sopa_array_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] ded; logic [7:0] out; logic [7:0] oe;} sopa_row_t;
  localparam int W = sopa_pkg::NUM_TERMS * sopa_pkg::ROW_BITS;
  function automatic logic [W-1:0] mk_map();
    logic [W-1:0] m;
    m = '0;
    // an unused term takes a line and its complement, so it stays low
    for (int t = 0; t < 64; t++) m[t*40 +: 2] = 2'b11;
    for (int g = 0; g < 8; g++) begin
      m[g*320 +: 2] = 2'b00;
      m[g*320 + ((g < 4) ? ((g == 3) ? 24 : 2*g) : 16)] = 1'b1;
      if (g >= 4) m[g*320 + 40 +: 2] = 2'b00;
      if (g >= 4) m[g*320 + 40 + 2*g] = 1'b1;
    end
    // output 7 also ors in the pin of output 4, so the io_in feedback path is exercised
    m[2320 +: 2] = 2'b00;
    m[2352] = 1'b1;
    return m;
  endfunction : mk_map
  logic        clk, reset_n, reg_clk_pin, oe_pin_n, preload_en, verify_req, tick;
  logic [11:0] ded_in;
  logic [7:0]  io_in, io_out, io_oe_n, preload_data;
  logic [5:0]  verify_row;
  logic [39:0] verify_data, vd_lock;
  int          n_fail, checks_done, cycles;
  sopa_row_t   rows [4] = '{'{12'h1FF, 8'h55, 8'h00}, '{12'h100, 8'hA2, 8'h00},
                            '{12'h0F0, 8'h0A, 8'hF0}, '{12'h10F, 8'hAD, 8'h00}};
  logic [5:0]  vr [4] = '{6'h00, 6'h01, 6'h18, 6'h20};
  logic [39:0] ve [4] = '{40'h1, 40'h3, 40'h100_0000, 40'h1_0000};
  sopa_array #(.AND_MAP(mk_map()), .POL_HIGH(8'h55), .REG_OUT(8'h0F)) u_dut (
    .clk(clk), .reset_n(reset_n), .ded_in(ded_in), .reg_clk_pin(reg_clk_pin), .oe_pin_n(oe_pin_n),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .preload_en(preload_en), .preload_data(preload_data),
    .verify_req(verify_req), .verify_row(verify_row), .verify_data(verify_data));
  sopa_array #(.AND_MAP(mk_map()), .POL_HIGH(8'h55), .REG_OUT(8'h0F), .SEC_LOCK(1'b1)) u_lock (
    .clk(clk), .reset_n(reset_n), .ded_in(ded_in), .reg_clk_pin(reg_clk_pin), .oe_pin_n(oe_pin_n),
    .io_in(io_in), .io_out(), .io_oe_n(), .preload_en(preload_en), .preload_data(preload_data),
    .verify_req(verify_req), .verify_row(verify_row), .verify_data(vd_lock));
  sopa_board u_board (.clk(clk), .reset_n(reset_n), .tick(tick), .io_out(io_out), .io_oe_n(io_oe_n),
    .io_in(io_in), .reg_clk_pin(reg_clk_pin));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask : cmp8
  task automatic cmp40(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp40
  // set the pins, let the sync settle, then one register clock
  task automatic step(input logic [11:0] d);
    ded_in = d;
    repeat (6) @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (16) @(negedge clk);
  endtask : step
  task automatic wrap_up();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    {reset_n, oe_pin_n, preload_en, verify_req, tick, ded_in, preload_data, verify_row} = '0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    cmp8(io_out, 8'hFF, 8'h0F);
    cmp8(io_oe_n, 8'hFF, 8'hFF);
    foreach (rows[i]) begin
      step(rows[i].ded);
      cmp8(io_out, rows[i].out, ~rows[i].oe);
      cmp8(io_oe_n, rows[i].oe, 8'hFF);
    end
    ded_in = 12'h000;
    repeat (8) @(negedge clk);
    cmp8(io_out, 8'h0D, 8'h0F);
    oe_pin_n = 1'b1;
    repeat (8) @(negedge clk);
    cmp8(io_oe_n, 8'hFF, 8'hFF);
    oe_pin_n = 1'b0;
    preload_en = 1'b1;
    preload_data = 8'h06;
    @(negedge clk);
    preload_en = 1'b0;
    repeat (2) @(negedge clk);
    cmp8(io_out, 8'h06, 8'h0F);
    step(12'h000);
    cmp8(io_out, 8'h0A, 8'h0F);
    foreach (vr[i]) begin
      verify_row = vr[i];
      verify_req = 1'b1;
      @(negedge clk);
      cmp40(verify_data, ve[i]);
      cmp40(vd_lock, 40'h0);
    end
    verify_req = 1'b0;
    reset_n = 1'b0;
    #1;
    cmp8(io_out, 8'hFF, 8'h0F);
    @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    cmp8(io_oe_n, 8'hFF, 8'h0F);
    @(negedge clk);
    wrap_up();
  end
endmodule : sopa_array_bench
